// [verilog/cbt_defines.vh]
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH

// Register byte offsets on the APB
`define CBT_ADDR_W 12
`define CBT_OFS_TIMING 12'h000
`define CBT_OFS_CONTROL 12'h004
`define CBT_OFS_STATUS 12'h008

// Timing register fields, all stored as functional value minus one
`define CBT_PRESC_MSB 4
`define CBT_PRESC_LSB 0
`define CBT_PRE_MSB 11
`define CBT_PRE_LSB 8
`define CBT_POST_MSB 14
`define CBT_POST_LSB 12
`define CBT_JUMP_MSB 17
`define CBT_JUMP_LSB 16
`define CBT_TIMING_MASK 32'h0003_7F1F
`define CBT_TIMING_RST 32'h0000_2300

// Control register fields
`define CBT_CTRL_RUN 0
`define CBT_CONTROL_RST 1'h0

// Status register fields
`define CBT_ST_RXBIT 0
`define CBT_ST_STATE_MSB 2
`define CBT_ST_STATE_LSB 1
`define CBT_ST_CNT_MSB 7
`define CBT_ST_CNT_LSB 3
`define CBT_ST_FRAME 8
`define CBT_ST_SYNCED 9
`define CBT_ST_RXLIVE 10

// Bus levels
`define CBT_RECESSIVE 1'h1
`define CBT_DOMINANT 1'h0

`endif

// [verilog/cbt_sync2.v]
`default_nettype none
// Two-stage synchronizer for the bus receive pin
module cbt_sync2 (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire d_i,
	output reg q_o
);
	reg meta_reg;

	// First stage feeds only the second stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'h1;
			q_o <= 1'h1;
		end else if (ce_i) begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule // cbt_sync2
`default_nettype wire

// [verilog/cbt_tq_gen.v]
`default_nettype none
// Time quantum strobe: one core cycle every div_i+1 cycles
module cbt_tq_gen #(
	parameter PW = 5
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire run_i,
	input wire [PW-1:0] div_i,
	output reg tick_o
);
	reg [PW-1:0] cnt_reg;

	// Counter restarts while stopped so the first quantum is whole
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= {PW{1'b0}};
			tick_o <= 1'h0;
		end else if (ce_i) begin
			if (!run_i) begin
				cnt_reg <= {PW{1'b0}};
				tick_o <= 1'h0;
			end else if (cnt_reg >= div_i) begin
				cnt_reg <= {PW{1'b0}};
				tick_o <= 1'h1;
			end else begin
				cnt_reg <= cnt_reg + {{(PW-1){1'b0}}, 1'b1};
				tick_o <= 1'h0;
			end
		end
	end
endmodule // cbt_tq_gen
`default_nettype wire

// [verilog/cbt_top.v]
// Our own choices: register access over APB and the register addresses.
`include "cbt_defines.vh"
`default_nettype none
module cbt_top #(
	parameter PRESC_W = 5
) (
	input wire CORE_CLK_I,
	input wire RST_I,
	input wire CE_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [`CBT_ADDR_W-1:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	input wire RX_I,
	input wire FRAME_IDLE_I,
	output reg SAMPLE_POINT_O,
	output reg RX_BIT_O,
	output reg HARD_SYNC_O,
	output reg RESYNC_O
);
	localparam ST_SYNC = 2'h0;
	localparam ST_SEG1 = 2'h1;
	localparam ST_SEG2 = 2'h2;

	// Configuration and control
	reg [31:0] timing_reg;
	reg run_reg;

	// Bit timing state and next values
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [4:0] cnt_reg;
	reg [4:0] cnt_next;
	reg [2:0] ext_reg;
	reg [2:0] ext_next;
	reg [2:0] shrink_reg;
	reg [2:0] shrink_next;
	reg synced_reg;
	reg synced_next;

	// Edge reference and frame tracking
	reg prev_sample_reg;
	reg frame_active_reg;
	reg idle_d_reg;

	// Sample strobe, synchronized bus level and quantum tick
	reg sample_now;
	wire rx_s;
	wire tq_tick;

	// Decoded configuration, functional lengths in quanta
	wire [PRESC_W-1:0] presc = timing_reg[`CBT_PRESC_MSB:`CBT_PRESC_LSB];
	wire [4:0] seg1_len = {1'b0, timing_reg[`CBT_PRE_MSB:`CBT_PRE_LSB]} + 5'h01;
	wire [3:0] post_len = {1'b0, timing_reg[`CBT_POST_MSB:`CBT_POST_LSB]} + 4'h1;
	wire [2:0] jump_len = {1'b0, timing_reg[`CBT_JUMP_MSB:`CBT_JUMP_LSB]} + 3'h1;

	// Prescaler; one tick marks one quantum
	cbt_tq_gen #(
		.PW(PRESC_W)
	) u_tq_gen (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.run_i(run_reg),
		.div_i(presc),
		.tick_o(tq_tick)
	);

	// Bus pin comes from another domain
	cbt_sync2 u_rx_sync (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.d_i(RX_I),
		.q_o(rx_s)
	);

	// Edge qualification, only falling edges after a recessive sample
	wire edge_ok = tq_tick && run_reg && !synced_reg && (prev_sample_reg == `CBT_RECESSIVE) &&
		(rx_s == `CBT_DOMINANT);
	wire hard = edge_ok && FRAME_IDLE_I && !frame_active_reg;
	wire resync = edge_ok && !hard;

	// Phase errors of a late and an early edge
	wire [4:0] late_err = cnt_reg + 5'h01;
	wire [4:0] early_err = {1'b0, post_len} - cnt_reg;
	wire [2:0] late_fix = (late_err < {2'h0, jump_len}) ? late_err[2:0] : jump_len;
	wire early_full = (early_err <= {2'h0, jump_len});

	// Adjustment that counts for this quantum; only the current bit keeps it
	wire [2:0] ext_use = resync ? late_fix : ext_reg;
	wire [2:0] shrink_use = resync ? jump_len : shrink_reg;
	// Last index of the pre-sample total and end test of the post buffer
	wire [4:0] seg1_end = seg1_len + {2'h0, ext_use} - 5'h01;
	wire [4:0] seg2_end = cnt_reg + 5'h01 + {2'h0, shrink_use};

	// Bit timing state machine, stepped once per quantum
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		ext_next = ext_reg;
		shrink_next = shrink_reg;
		synced_next = synced_reg;
		sample_now = 1'b0;
		if (!run_reg) begin
			state_next = ST_SYNC;
			cnt_next = 5'h00;
			ext_next = 3'h0;
			shrink_next = 3'h0;
			synced_next = 1'b0;
		end else if (tq_tick) begin
			if (edge_ok) begin
				synced_next = 1'b1;
			end
			case (state_reg)
				ST_SYNC: begin
					// Edge here has zero error; bit proceeds unchanged
					state_next = ST_SEG1;
					cnt_next = 5'h00;
					ext_next = 3'h0;
				end
				ST_SEG1: begin
					if (hard) begin
						// Edge quantum becomes the sync slot
						cnt_next = 5'h00;
						ext_next = 3'h0;
					end else begin
						// A late edge stretches the pre-sample total
						ext_next = ext_use;
						if (cnt_reg >= seg1_end) begin
							// Sample point between the two buffers
							sample_now = 1'b1;
							synced_next = 1'b0;
							state_next = ST_SEG2;
							cnt_next = 5'h00;
							shrink_next = 3'h0;
						end else begin
							cnt_next = cnt_reg + 5'h01;
						end
					end
				end
				ST_SEG2: begin
					if (hard) begin
						// Restart regardless of the phase error
						state_next = ST_SEG1;
						cnt_next = 5'h00;
						ext_next = 3'h0;
					end else if (resync && early_full) begin
						// Edge quantum becomes the edge slot of the new bit
						state_next = ST_SEG1;
						cnt_next = 5'h00;
						ext_next = 3'h0;
					end else begin
						// A partly compensated early edge keeps the sync slot
						shrink_next = shrink_use;
						if (seg2_end >= {1'b0, post_len}) begin
							// Nominal lengths return for the next bit
							state_next = ST_SYNC;
							cnt_next = 5'h00;
							ext_next = 3'h0;
							shrink_next = 3'h0;
						end else begin
							cnt_next = cnt_reg + 5'h01;
						end
					end
				end
				default: begin
					state_next = ST_SYNC;
					cnt_next = 5'h00;
				end
			endcase
		end
	end

	// Timing state and bit hand-over
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_reg <= ST_SYNC;
			cnt_reg <= 5'h00;
			ext_reg <= 3'h0;
			shrink_reg <= 3'h0;
			synced_reg <= 1'b0;
			prev_sample_reg <= `CBT_RECESSIVE;
			SAMPLE_POINT_O <= 1'b0;
			RX_BIT_O <= `CBT_RECESSIVE;
			HARD_SYNC_O <= 1'b0;
			RESYNC_O <= 1'b0;
		end else if (CE_I) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ext_reg <= ext_next;
			shrink_reg <= shrink_next;
			synced_reg <= synced_next;
			SAMPLE_POINT_O <= sample_now;
			// Sync pulses tell which kind of edge was taken
			HARD_SYNC_O <= hard && run_reg;
			RESYNC_O <= resync && run_reg;
			if (!run_reg) begin
				prev_sample_reg <= `CBT_RECESSIVE;
			end else if (sample_now) begin
				prev_sample_reg <= rx_s;
				RX_BIT_O <= rx_s;
			end
		end
	end

	// Frame tracking; hard sync sets it, return to idle clears it, set wins
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			frame_active_reg <= 1'b0;
			idle_d_reg <= 1'b1; // Idle level, so no false rising edge
		end else if (CE_I) begin
			idle_d_reg <= FRAME_IDLE_I;
			if (hard) begin
				frame_active_reg <= 1'b1;
			end else if (!run_reg || (FRAME_IDLE_I && !idle_d_reg)) begin
				frame_active_reg <= 1'b0;
			end
		end
	end

	// APB slave with one wait state; registered answer keeps outputs flopped
	wire apb_acc = PSEL_I && PENABLE_I && !PREADY_O;
	wire [31:0] status_word = {
		21'h0, // Unused upper bits
		rx_s, // Live level, before any sample point
		synced_reg,
		frame_active_reg,
		cnt_reg,
		state_reg,
		RX_BIT_O
	};

	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			timing_reg <= `CBT_TIMING_RST;
			run_reg <= `CBT_CONTROL_RST;
			PRDATA_O <= 32'h0000_0000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else if (CE_I) begin
			PREADY_O <= apb_acc;
			PSLVERR_O <= 1'b0;
			if (apb_acc) begin
				PRDATA_O <= 32'h0000_0000;
				case (PADDR_I)
					`CBT_OFS_TIMING: begin
						// Limits of the programmed values are left to software
						if (PWRITE_I) begin
							timing_reg <= PWDATA_I & `CBT_TIMING_MASK;
						end else begin
							PRDATA_O <= timing_reg;
						end
					end
					`CBT_OFS_CONTROL: begin
						// Clearing run stops the prescaler and the bit timing
						if (PWRITE_I) begin
							run_reg <= PWDATA_I[`CBT_CTRL_RUN];
						end else begin
							PRDATA_O <= {31'h0, run_reg};
						end
					end
					`CBT_OFS_STATUS: begin
						// Writes to status are ignored
						if (!PWRITE_I) begin
							PRDATA_O <= status_word;
						end
					end
					default: begin
						// Unmapped offset answers with an error, no state change
						PSLVERR_O <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule // cbt_top
`default_nettype wire

// [test/cbt_bus_node.sv]
`default_nettype none
// Far-side node seen through the transceiver, with a fixed delay
module cbt_bus_node #(
	parameter int DLY = 2
) (
	input wire logic clk_i,
	input wire logic level_i,
	output logic rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DLY-1:0] line_q = '1;
	// Cable and transceiver delay; an idle bus reads recessive
	always @(posedge clk_i) begin
		line_q <= {line_q[DLY-2:0], level_i};
	end
	assign rx_o = line_q[DLY-1];
endmodule // cbt_bus_node
`default_nettype wire

// [test/cbt_top_assertions.sv]
`include "cbt_defines.vh"
`default_nettype none
module cbt_top_assertions (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic FRAME_IDLE_I,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic SAMPLE_POINT_O,
	input wire logic RX_BIT_O,
	input wire logic HARD_SYNC_O,
	input wire logic RESYNC_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	logic sync_seen;
	logic frame_seen;
	logic idle_q;
	wire logic any_sync = HARD_SYNC_O | RESYNC_O;
	wire logic [5:0] out_vec = {PREADY_O, PSLVERR_O, SAMPLE_POINT_O, RX_BIT_O, HARD_SYNC_O,
		RESYNC_O};
	// Sample point reopens sync; rising idle ends the frame
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			sync_seen <= 1'h0;
			frame_seen <= 1'h0;
			idle_q <= 1'h1;
		end else if (CE_I) begin
			sync_seen <= SAMPLE_POINT_O ? 1'h0 : (sync_seen | any_sync);
			frame_seen <= HARD_SYNC_O ? 1'h1 : ((FRAME_IDLE_I && !idle_q) ? 1'h0 : frame_seen);
			idle_q <= FRAME_IDLE_I;
		end
	end
	sequence s_access;
		PSEL_I && PENABLE_I && !PREADY_O && CE_I;
	endsequence
	sequence s_quiet;
		!SAMPLE_POINT_O [*2];
	endsequence
	a_ready_wait: assert property (s_access |=> PREADY_O) else $error("ready missing");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
	a_sample_gap: assert property (SAMPLE_POINT_O |=> s_quiet) else $error("samples too close");
	a_rxbit_hold: assert property (!SAMPLE_POINT_O |-> $stable(RX_BIT_O))
		else $error("bit moved off sample point");
	a_single_sync: assert property (any_sync |-> !sync_seen) else $error("second sync");
	a_hard_idle: assert property (HARD_SYNC_O |-> $past(FRAME_IDLE_I))
		else $error("hard sync in frame");
	a_hard_once: assert property (HARD_SYNC_O |-> !frame_seen) else $error("repeat hard sync");
	a_sync_kind: assert property (!(HARD_SYNC_O && RESYNC_O)) else $error("both syncs");
	a_sync_recess: assert property (any_sync |-> $past(RX_BIT_O) == `CBT_RECESSIVE)
		else $error("sync after dominant sample");
	a_ce_freeze: assert property (!CE_I |=> $stable(out_vec))
		else $error("outputs moved while frozen");
endmodule // cbt_top_assertions
`default_nettype wire

// [test/can_bit_timing_sync_tb_top.sv]
`include "cbt_defines.vh"
`default_nettype none
module can_bit_timing_sync_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic pen = 1'h0;
	logic pwr = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic level = 1'h1;
	logic idle = 1'h1;
	logic ce = 1'h1;
	wire logic rx;
	logic [31:0] prdata;
	logic pready, pslverr, sp, rxbit, hs, rs;
	int bad_count = 0;
	int checks = 0;
	int t = 0;
	// Clock and cycle count
	always #5 clk = ~clk;
	always @(posedge clk) t <= t + 1;
	cbt_bus_node i_node (.clk_i(clk), .level_i(level), .rx_o(rx));
	cbt_top i_dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .FRAME_IDLE_I(idle),
		.SAMPLE_POINT_O(sp), .RX_BIT_O(rxbit), .HARD_SYNC_O(hs), .RESYNC_O(rs));
	task report_and_stop;
		$display("mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task give_up;
		bad_count++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop;
	endtask
	// One APB transfer; request held until pready is seen at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
			give_up;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	// Bounded wait for a pulse: 0 sample point, 1 resync, 2 hard sync
	task wsig(input int sel, output int at);
		int n;
		logic s;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			s = (sel == 0) ? sp : ((sel == 1) ? rs : hs);
		end while (s !== 1'h1 && n < 600);
		if (s !== 1'h1)
			give_up;
		at = t;
	endtask
	task cfg(input logic [31:0] tv);
		logic [31:0] d;
		logic e;
		apb(1'h1, `CBT_OFS_CONTROL, 32'h0000_0000, d, e);
		apb(1'h1, `CBT_OFS_TIMING, tv, d, e);
		apb(1'h1, `CBT_OFS_CONTROL, 32'h0000_0001, d, e);
	endtask
	task s_regs;
		logic [31:0] d;
		logic e;
		apb(1'h0, `CBT_OFS_TIMING, 32'h0000_0000, d, e);
		chk(d, `CBT_TIMING_RST);
		chk({31'h0000_0000, e}, 32'h0000_0000);
		apb(1'h0, `CBT_OFS_CONTROL, 32'h0000_0000, d, e);
		chk(d, {31'h0000_0000, `CBT_CONTROL_RST});
		apb(1'h1, `CBT_OFS_TIMING, 32'hFFFF_FFFF, d, e);
		apb(1'h0, `CBT_OFS_TIMING, 32'h0000_0000, d, e);
		chk(d, `CBT_TIMING_MASK);
		apb(1'h0, 12'h00C, 32'h0000_0000, d, e);
		chk({31'h0000_0000, e}, 32'h0000_0001);
	endtask
	// Idle recessive bus: bit length at the prescaler extremes
	task s_nominal;
		int a, b;
		for (int p = 0; p < 32; p += 31) begin
			cfg(32'h0000_2300 | p);
			wsig(0, a);
			wsig(0, a);
			wsig(0, b);
			chk(b - a, 8 * (p + 1));
		end
	endtask
	task s_hard;
		int h, s;
		logic [31:0] d;
		logic e;
		cfg(32'h0001_2301);
		wsig(0, s);
		@(posedge clk);
		level <= 1'h0;
		wsig(2, h);
		wsig(0, s);
		chk(s - h, 8);
		chk({31'h0000_0000, rxbit}, {31'h0000_0000, `CBT_DOMINANT});
		apb(1'h0, `CBT_OFS_STATUS, 32'h0000_0000, d, e);
		chk(d & 32'h0000_0501, 32'h0000_0100);
	endtask
	// Clock enable low for ten cycles stretches one bit by ten cycles
	task s_freeze;
		int a, b;
		wsig(0, a);
		@(posedge clk);
		ce <= 1'h0;
		repeat (10) @(posedge clk);
		ce <= 1'h1;
		wsig(0, b);
		chk(b - a, 26);
	endtask
	// Edge swept across a bit in frame; jump limit 2, pre 4, post 3
	task s_resync;
		int s, r, p, q, e, ex;
		@(posedge clk);
		idle <= 1'h0;
		level <= 1'h1;
		wsig(0, s);
		wsig(0, s);
		for (int d = 0; d < 14; d++) begin
			repeat (d + 1) @(posedge clk);
			level <= 1'h0;
			wsig(1, r);
			wsig(0, p);
			e = ((r - s) / 2 - 1) % 8 - 3;
			ex = 4;
			if (e > 2)
				ex = ex - (e - 2);
			if (-e > 2)
				ex = ex + (-e - 2);
			chk(p - r, 2 * ex);
			@(posedge clk);
			level <= 1'h1;
			wsig(0, q);
			chk(q - p, 16);
			s = q;
		end
	endtask
	// Reset, then the scenarios in order
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		s_regs;
		s_nominal;
		s_hard;
		s_freeze;
		s_resync;
		report_and_stop;
	end
endmodule // can_bit_timing_sync_tb_top
bind cbt_top cbt_top_assertions i_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .FRAME_IDLE_I(FRAME_IDLE_I), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .SAMPLE_POINT_O(SAMPLE_POINT_O), .RX_BIT_O(RX_BIT_O),
	.HARD_SYNC_O(HARD_SYNC_O), .RESYNC_O(RESYNC_O));
`default_nettype wire
